// file: clock_source_unit_defines.vh
// constants for the clock source unit: register offsets, fields, resets
// assumes a 32-bit apb slave with word-aligned registers
`ifndef CLOCK_SOURCE_UNIT_DEFINES_VH
`define CLOCK_SOURCE_UNIT_DEFINES_VH

// ==========================================================
// register byte offsets
`define CTRL_ONE_OFFSET 12'h000
`define CTRL_TWO_OFFSET 12'h004
`define TRIM_OFFSET 12'h008
`define STATUS_OFFSET 12'h00C

// ==========================================================
// control one fields
`define SRC_SEL_MSB 7
`define SRC_SEL_LSB 6
`define REF_DIV_MSB 5
`define REF_DIV_LSB 3
`define INT_REF_SEL_BIT 2
`define INT_CLK_EN_BIT 1
`define INT_STOP_EN_BIT 0
`define CTRL_ONE_RESET 8'h04

// ==========================================================
// control two fields
`define BUS_DIV_MSB 7
`define BUS_DIV_LSB 6
`define RANGE_BIT 5
`define HIGH_GAIN_BIT 4
`define LOW_POWER_BIT 3
`define EXT_SRC_SEL_BIT 2
`define EXT_CLK_EN_BIT 1
`define EXT_STOP_EN_BIT 0
`define CTRL_TWO_RESET 8'h40

// ==========================================================
// trim
`define TRIM_WIDTH 9
`define TRIM_RESET 9'h100

// ==========================================================
// clock source select encodings
`define SRC_FLL 2'h0
`define SRC_INT 2'h1
`define SRC_EXT 2'h2

`endif

// file: ratio_divider.v
// power-of-two divider producing a one-cycle enable pulse
// assumes an input enable pulse from the same clock domain
`timescale 1ns/10ps
`default_nettype none

module ratio_divider #(
	parameter SEL_WIDTH = 3,
	parameter CNT_WIDTH = 7
) (
	// clock and reset
	input wire core_clk,
	input wire srst,
	// control
	input wire run,
	input wire in_en,
	input wire [SEL_WIDTH-1:0] ratio_sel,
	// output
	output reg out_en
);

	// ==========================================================
	// counter
	reg [CNT_WIDTH-1:0] count_reg;
	wire [CNT_WIDTH-1:0] mask;

	assign mask = ~({CNT_WIDTH{1'b1}} << ratio_sel);

	always @(posedge core_clk) begin
		if (srst || !run) begin
			count_reg <= {CNT_WIDTH{1'b0}};
			out_en <= 1'b0;
		end else if (in_en) begin
			out_en <= ((count_reg & mask) == mask);
			count_reg <= count_reg + {{(CNT_WIDTH-1){1'b0}}, 1'b1};
		end else begin
			out_en <= 1'b0;
		end
	end

endmodule

`default_nettype wire

// file: clock_source_unit.v
// Operation
// - reset selects fll engaged internal mode, fll using internal reference
// - bus clock enable is half the divided output clock rate
// - selected source divided by 1, 2, 4 or 8 from two-bit field
// - fll reference divided by ratio from three-bit field
// - internal reference adjustable by nine trim bits
// - debug clock is oscillator output divided by two while fll runs
// - engaged internal: output from fll on internal reference, debug from fll
// - engaged external: output from fll on external reference, debug from fll
// - bypassed internal: fll on, output from internal reference, debug clock
// - bypassed internal low power: fll off, internal output, no debug clock
// - bypassed external: fll on, output from external reference, debug clock
// - bypassed external low power: fll off, external output, no debug
// - drives gain, range, source select, enable, stop enable to oscillator
// - stop disables fll, system and debug clocks; references per stop enable
// - fll reference input is at most 5 mhz
// - bus divider field resets to 01, divide by two
// - reference divider is two to the field power, 1 to 128
// - low power bit disables fll in bypass unless debug active
// - reference select bit: 1 internal, 0 external
//
// clock source unit: mode control, dividers and apb register file
// assumes reference and oscillator ticks arrive asynchronously from pins
`timescale 1ns/10ps
`default_nettype none
`include "clock_source_unit_defines.vh"

module clock_source_unit (
	// clock and reset
	input wire core_clk,
	input wire srst,
	// apb slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// clock ticks from analog sources
	input wire int_ref_tick,
	input wire ext_ref_tick,
	input wire osc_tick,
	// system state
	input wire stop_req,
	input wire background_debug_active,
	// clock enables out
	output reg divided_output_clock,
	output reg bus_clk_en,
	output reg debug_clk_en,
	output reg fll_ref_en,
	output reg fll_enable,
	output reg fll_on_internal,
	// internal reference control
	output reg [8:0] int_ref_trim,
	output reg int_ref_enable,
	// external low power oscillator control
	output reg high_gain_select,
	output reg osc_range_high,
	output reg ext_ref_source_select,
	output reg ext_ref_clock_enable,
	output reg ext_ref_stop_enable,
	output reg ext_ref_enable,
	// mode status
	output reg [6:0] mode_state
);

	// ==========================================================
	// modes, one-hot
	localparam [6:0] M_ENG_I = 7'h01;
	localparam [6:0] M_ENG_E = 7'h02;
	localparam [6:0] M_BYP_I = 7'h04;
	localparam [6:0] M_BYP_IL = 7'h08;
	localparam [6:0] M_BYP_E = 7'h10;
	localparam [6:0] M_BYP_EL = 7'h20;
	localparam [6:0] M_STOP = 7'h40;

	// ==========================================================
	// registers
	reg [7:0] clock_control_one_reg;
	reg [7:0] clock_control_two_reg;
	reg [8:0] trim_reg;
	reg [6:0] mode_next;
	reg [2:0] int_sync_reg, ext_sync_reg, osc_sync_reg;
	reg [1:0] bus_phase_reg;
	reg stop_s1_reg, stop_s2_reg, dbg_s1_reg, dbg_s2_reg;
	reg osc_half_reg;
	reg in_stop_reg;

	wire [1:0] clock_source_select;
	wire [2:0] reference_divider_field;
	wire int_ref_select;
	wire low_power_bit;
	wire [1:0] bus_divider_field;
	wire int_edge, ext_edge, osc_edge;
	wire fll_run;
	wire ref_tick;
	wire src_tick;
	wire div_out;
	wire ref_div_out;
	wire wr_en;
	wire rd_en;

	assign clock_source_select =
		clock_control_one_reg[`SRC_SEL_MSB:`SRC_SEL_LSB];
	assign reference_divider_field =
		clock_control_one_reg[`REF_DIV_MSB:`REF_DIV_LSB];
	assign int_ref_select = clock_control_one_reg[`INT_REF_SEL_BIT];
	assign bus_divider_field =
		clock_control_two_reg[`BUS_DIV_MSB:`BUS_DIV_LSB];
	assign low_power_bit = clock_control_two_reg[`LOW_POWER_BIT];
	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && !penable && !pwrite;

	// ==========================================================
	// pin synchronisers and edge detection
	always @(posedge core_clk) begin
		if (srst) begin
			int_sync_reg <= 3'h0;
			ext_sync_reg <= 3'h0;
			osc_sync_reg <= 3'h0;
			stop_s1_reg <= 1'b0;
			stop_s2_reg <= 1'b0;
			dbg_s1_reg <= 1'b0;
			dbg_s2_reg <= 1'b0;
		end else begin
			int_sync_reg <= {int_sync_reg[1:0], int_ref_tick};
			ext_sync_reg <= {ext_sync_reg[1:0], ext_ref_tick};
			osc_sync_reg <= {osc_sync_reg[1:0], osc_tick};
			stop_s1_reg <= stop_req;
			stop_s2_reg <= stop_s1_reg;
			dbg_s1_reg <= background_debug_active;
			dbg_s2_reg <= dbg_s1_reg;
		end
	end

	assign int_edge = int_sync_reg[1] && !int_sync_reg[2];
	assign ext_edge = ext_sync_reg[1] && !ext_sync_reg[2];
	assign osc_edge = osc_sync_reg[1] && !osc_sync_reg[2];

	// ==========================================================
	// apb register file
	always @(posedge core_clk) begin
		if (srst) begin
			clock_control_one_reg <= `CTRL_ONE_RESET;
			clock_control_two_reg <= `CTRL_TWO_RESET;
			trim_reg <= `TRIM_RESET;
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= 1'b0;
			if (wr_en && pready) begin
				case (paddr)
				`CTRL_ONE_OFFSET: begin
					clock_control_one_reg <= pwdata[7:0];
				end
				`CTRL_TWO_OFFSET: begin
					clock_control_two_reg <= pwdata[7:0];
				end
				`TRIM_OFFSET: begin
					trim_reg <= pwdata[8:0];
				end
				default: begin
				end
				endcase
			end
			if (psel && !penable) begin
				pslverr <= (paddr != `CTRL_ONE_OFFSET) &&
					(paddr != `CTRL_TWO_OFFSET) &&
					(paddr != `TRIM_OFFSET) &&
					(paddr != `STATUS_OFFSET);
			end
			if (rd_en) begin
				case (paddr)
				`CTRL_ONE_OFFSET: prdata <= {24'h000000, clock_control_one_reg};
				`CTRL_TWO_OFFSET: prdata <= {24'h000000, clock_control_two_reg};
				`TRIM_OFFSET: prdata <= {23'h000000, trim_reg};
				`STATUS_OFFSET: prdata <= {25'h0000000, mode_state};
				default: prdata <= 32'h00000000;
				endcase
			end
		end
	end

	// ==========================================================
	// mode selection
	always @* begin
		mode_next = M_ENG_I;
		if (stop_s2_reg) begin
			mode_next = M_STOP;
		end else begin
			case (clock_source_select)
			`SRC_FLL: begin
				mode_next = int_ref_select ? M_ENG_I : M_ENG_E;
			end
			`SRC_INT: begin
				mode_next = (low_power_bit && !dbg_s2_reg) ?
					M_BYP_IL : M_BYP_I;
			end
			`SRC_EXT: begin
				mode_next = (low_power_bit && !dbg_s2_reg) ?
					M_BYP_EL : M_BYP_E;
			end
			default: begin
				mode_next = int_ref_select ? M_ENG_I : M_ENG_E;
			end
			endcase
		end
	end

	always @(posedge core_clk) begin
		if (srst) begin
			mode_state <= M_ENG_I;
			in_stop_reg <= 1'b0;
		end else begin
			mode_state <= mode_next;
			in_stop_reg <= stop_s2_reg;
		end
	end

	// fll runs unless in low power bypass or stop
	assign fll_run = (mode_state == M_ENG_I) || (mode_state == M_ENG_E) ||
		(mode_state == M_BYP_I) || (mode_state == M_BYP_E);

	// fll reference by reference select bit, output source by mode
	assign ref_tick = int_ref_select ? int_edge : ext_edge;
	assign src_tick =
		((mode_state == M_ENG_I) || (mode_state == M_ENG_E)) ?
		osc_edge :
		((mode_state == M_BYP_I) || (mode_state == M_BYP_IL)) ?
		int_edge :
		((mode_state == M_BYP_E) || (mode_state == M_BYP_EL)) ?
		ext_edge :
		1'b0;

	// ==========================================================
	// dividers
	ratio_divider #(
		.SEL_WIDTH(2),
		.CNT_WIDTH(3)
	) bus_divider (
		.core_clk(core_clk),
		.srst(srst),
		.run(mode_state != M_STOP),
		.in_en(src_tick),
		.ratio_sel(bus_divider_field),
		.out_en(div_out)
	);

	ratio_divider #(
		.SEL_WIDTH(3),
		.CNT_WIDTH(7)
	) ref_divider (
		.core_clk(core_clk),
		.srst(srst),
		.run(fll_run),
		.in_en(ref_tick),
		.ratio_sel(reference_divider_field),
		.out_en(ref_div_out)
	);

	// ==========================================================
	// output enables and control
	always @(posedge core_clk) begin
		if (srst) begin
			divided_output_clock <= 1'b0;
			bus_clk_en <= 1'b0;
			bus_phase_reg <= 2'h0;
			debug_clk_en <= 1'b0;
			osc_half_reg <= 1'b0;
			fll_ref_en <= 1'b0;
			fll_enable <= 1'b1;
			fll_on_internal <= 1'b1;
			int_ref_trim <= `TRIM_RESET;
			int_ref_enable <= 1'b1;
			high_gain_select <= 1'b0;
			osc_range_high <= 1'b0;
			ext_ref_source_select <= 1'b0;
			ext_ref_clock_enable <= 1'b0;
			ext_ref_stop_enable <= 1'b0;
			ext_ref_enable <= 1'b0;
		end else begin
			divided_output_clock <= div_out;
			bus_clk_en <= 1'b0;
			if (div_out) begin
				bus_phase_reg <= bus_phase_reg + 2'h1;
				bus_clk_en <= bus_phase_reg[0];
			end
			debug_clk_en <= 1'b0;
			if (!fll_run) begin
				osc_half_reg <= 1'b0;
			end else if (osc_edge) begin
				osc_half_reg <= ~osc_half_reg;
				debug_clk_en <= osc_half_reg;
			end
			fll_ref_en <= ref_div_out && fll_run;
			fll_enable <= fll_run;
			fll_on_internal <= int_ref_select;
			int_ref_trim <= trim_reg;
			int_ref_enable <= in_stop_reg ?
				clock_control_one_reg[`INT_STOP_EN_BIT] : 1'b1;
			high_gain_select <= clock_control_two_reg[`HIGH_GAIN_BIT];
			osc_range_high <= clock_control_two_reg[`RANGE_BIT];
			ext_ref_source_select <= clock_control_two_reg[`EXT_SRC_SEL_BIT];
			ext_ref_clock_enable <= clock_control_two_reg[`EXT_CLK_EN_BIT];
			ext_ref_stop_enable <= clock_control_two_reg[`EXT_STOP_EN_BIT];
			ext_ref_enable <= in_stop_reg ?
				clock_control_two_reg[`EXT_STOP_EN_BIT] :
				(clock_control_two_reg[`EXT_CLK_EN_BIT] || !int_ref_select ||
				clock_source_select == `SRC_EXT);
		end
	end

endmodule

`default_nettype wire

// file: ref_clock_sources.sv
// reference and oscillator tick sources beside the clock source unit
// assumes enables from the unit; stopped sources stand low
`timescale 1ns/10ps
`default_nettype none
module ref_clock_sources (
	// enables from the unit
	input wire logic int_on,
	input wire logic ext_on,
	// tick pins
	output logic int_tick,
	output logic ext_tick,
	output logic osc_tick
);
	logic i = 1'b0;
	logic x = 1'b0;
	logic o = 1'b0;
	// ==========================================
	// free sources; reference ticks gated by the unit's enables, oscillator ungated
	always #100 i = ~i;
	always #120 x = ~x;
	always #20 o = ~o;
	assign int_tick = i & int_on;
	assign ext_tick = x & ext_on;
	assign osc_tick = o;
endmodule
`default_nettype wire

// file: csu_sva.sv
// port assertions for the clock source unit
// assumes one clock domain and apb with one access cycle
`timescale 1ns/10ps
`default_nettype none
module csu_sva (
	// clock, reset, apb
	input wire logic core_clk,
	input wire logic srst,
	input wire logic pready,
	input wire logic pwrite,
	input wire logic pslverr,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	// debug input and block outputs
	input wire logic background_debug_active,
	input wire logic divided_output_clock,
	input wire logic debug_clk_en,
	input wire logic fll_ref_en,
	input wire logic fll_enable,
	input wire logic fll_on_internal,
	input wire logic [8:0] int_ref_trim,
	input wire logic high_gain_select,
	input wire logic osc_range_high,
	input wire logic [6:0] mode_state
);
	wire logic wr = pready && pwrite && !pslverr;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);
	// ==========================================
	// properties
	rst_mode_a: assert property ($fell(srst) |->
		mode_state == 7'h01 && fll_enable && fll_on_internal)
		else $error("reset mode wrong");
	rst_trim_a: assert property ($fell(srst) |-> int_ref_trim == 9'h100)
		else $error("reset trim wrong");
	lpi_fll_a: assert property ($rose(mode_state[3]) &&
		!background_debug_active |-> ##1 !fll_enable)
		else $error("fll on in internal low power");
	lpe_fll_a: assert property ($rose(mode_state[5]) &&
		!background_debug_active |-> ##1 !fll_enable)
		else $error("fll on in external low power");
	stop_quiet_a: assert property (mode_state[6] [*3] |->
		!fll_enable && !divided_output_clock && !debug_clk_en)
		else $error("clocks in stop");
	fll_quiet_a: assert property (!fll_enable [*2] |->
		!debug_clk_en && !fll_ref_en)
		else $error("fll pulses while off");
	mode_hot_a: assert property ($onehot(mode_state))
		else $error("mode not one hot");
	osc_cfg_a: assert property (wr && paddr == 12'h004 |=> ##1
		high_gain_select == $past(pwdata[4], 2) &&
		osc_range_high == $past(pwdata[5], 2))
		else $error("oscillator controls wrong");
	ref_sel_a: assert property (wr && paddr == 12'h000 |=> ##1
		fll_on_internal == $past(pwdata[2], 2))
		else $error("reference select wrong");
	trim_wr_a: assert property (wr && paddr == 12'h008 |=> ##1
		int_ref_trim == $past(pwdata[8:0], 2))
		else $error("trim not stored");
endmodule
bind clock_source_unit csu_sva u_sva (.*);
`default_nettype wire

// file: tb_top.sv
// testbench for the clock source unit
// assumes ref_clock_sources on the tick pins and apb at 200 mhz
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic core_clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, stop_req = 1'b0, background_debug_active = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, er, divided_output_clock, bus_clk_en;
	logic debug_clk_en, fll_ref_en, fll_enable, fll_on_internal;
	logic int_ref_enable, high_gain_select, osc_range_high;
	logic ext_ref_source_select, ext_ref_clock_enable;
	logic ext_ref_stop_enable, ext_ref_enable;
	logic [8:0] int_ref_trim;
	logic [6:0] mode_state;
	wire logic int_ref_tick, ext_ref_tick, osc_tick;
	int err_count = 0, n_compared = 0, cyc = 0, cd = 0, cb = 0, cg = 0;
	int cf = 0;
	clock_source_unit u_dut (.*);
	ref_clock_sources u_src (.int_on(int_ref_enable),
		.ext_on(ext_ref_enable), .int_tick(int_ref_tick),
		.ext_tick(ext_ref_tick), .osc_tick(osc_tick));
	initial begin
		forever #2.5 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cd <= cd + divided_output_clock;
		cb <= cb + bus_clk_en;
		cg <= cg + debug_clk_en;
		cf <= cf + fll_ref_en;
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			err_count++;
			final_report;
		end
	end
	// ==========================================
	// shared tasks
	task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			err_count++;
			$display("[FAIL] %0t got %h expected %h", $time, g, e);
		end
	endtask
	task near(input int g, input int e);
		n_compared++;
		if (g < e - 1 || g > e + 1) begin
			err_count++;
			$display("[FAIL] %0t count %0d expected %0d", $time, g, e);
		end
	endtask
	task final_report;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// ==========================================
	// scenarios
	task t_reset;
		apb(12'h000, 1'b0, 32'h0);
		chk(rd, 32'h04);
		apb(12'h004, 1'b0, 32'h0);
		chk(rd, 32'h40);
		apb(12'h00C, 1'b0, 32'h0);
		chk(rd, 32'h01);
		apb(12'h008, 1'b1, 32'h1AB);
		apb(12'h008, 1'b0, 32'h0);
		chk(rd, 32'h1AB);
		apb(12'h004, 1'b1, 32'h77);
		repeat (2) @(posedge core_clk);
		chk({high_gain_select, osc_range_high, ext_ref_source_select,
			ext_ref_clock_enable, ext_ref_stop_enable}, 32'h1F);
	endtask
	task t_modes;
		logic [7:0] c1 [6];
		logic [6:0] ms [6];
		logic low_pwr;
		c1 = '{8'h04, 8'h00, 8'h44, 8'h44, 8'h80, 8'h80};
		ms = '{7'h01, 7'h02, 7'h04, 7'h08, 7'h10, 7'h20};
		for (int i = 0; i < 6; i++) begin
			low_pwr = ms[i][3] | ms[i][5];
			apb(12'h004, 1'b1, {24'h0, 4'h4, low_pwr, 3'h0});
			apb(12'h000, 1'b1, {24'h0, c1[i]});
			repeat (4) @(posedge core_clk);
			apb(12'h00C, 1'b0, 32'h0);
			chk(rd, {25'h0, ms[i]});
			chk(fll_enable, !low_pwr);
		end
		apb(12'h00C, 1'b1, 32'h7F);
		apb(12'h00C, 1'b0, 32'h0);
		chk(rd, 32'h20);
		apb(12'h010, 1'b1, 32'hFF);
		chk(er, 1'b1);
		apb(12'h010, 1'b0, 32'h0);
		chk(er, 1'b1);
		chk(rd, 32'h0);
	endtask
	task t_div;
		int s, sb, sg, sf, e;
		apb(12'h000, 1'b1, 32'h44);
		for (int b = 0; b < 4; b++) begin
			apb(12'h004, 1'b1, b << 6);
			s = cd;
			sb = cb;
			repeat (16) @(posedge int_ref_tick);
			e = 16 >> b;
			near(cd - s, e);
			near(cb - sb, e / 2);
		end
		sg = cg;
		sf = cf;
		repeat (800) @(posedge core_clk);
		near(cg - sg, 50);
		near(cf - sf, 20);
	endtask
	task t_stop;
		int s, sg;
		stop_req <= 1'b1;
		repeat (8) @(posedge core_clk);
		chk({mode_state, fll_enable}, 8'h80);
		chk({int_ref_enable, ext_ref_enable}, 32'h0);
		s = cd;
		sg = cg;
		repeat (300) @(posedge core_clk);
		chk(cd - s + cg - sg, 32'h0);
		stop_req <= 1'b0;
		apb(12'h004, 1'b1, 32'h48);
		background_debug_active <= 1'b1;
		repeat (8) @(posedge core_clk);
		chk({mode_state, fll_enable}, 8'h09);
		background_debug_active <= 1'b0;
		repeat (8) @(posedge core_clk);
		chk(fll_enable, 1'b0);
	endtask
	initial begin
		repeat (20) @(posedge core_clk);
		srst <= 1'b0;
		t_reset;
		t_modes;
		t_div;
		t_stop;
		final_report;
	end
endmodule
`default_nettype wire
